// ### fpc_pkg.sv
package fpc_pkg;

   localparam int NIB_W  = 4;
   localparam int CODE_W = 5;
   localparam int LFSR_W = 11;
   localparam int WIN_W  = 10;
   localparam int EV_N   = 3;

   // Key stream taps of the eleven-bit scrambler, x^11 + x^9 + 1.
   localparam int TAP_HI = 10;
   localparam int TAP_LO = 8;

   // Upper seed bits; the management address fills the low five.
   localparam logic [5:0] SEED_UPPER = 6'h21;

   localparam logic [4:0] CODE_IDLE = 5'h1f;
   localparam logic [4:0] CODE_J    = 5'h18;
   localparam logic [4:0] CODE_K    = 5'h11;
   localparam logic [4:0] CODE_T    = 5'h0d;
   localparam logic [4:0] CODE_R    = 5'h07;
   localparam logic [4:0] CODE_HALT = 5'h04;

   localparam logic [9:0] WIN_ONES  = 10'h3ff;
   localparam logic [3:0] PREAMBLE_NIBBLE = 4'h5;
   localparam logic [2:0] SYM_LAST     = 3'h4;
   localparam logic [2:0] CONFIRM_LAST = 3'h2;
   localparam logic [3:0] LOCK_BITS    = 4'hb;

   localparam logic [1:0] MLT_PLUS  = 2'h1;
   localparam logic [1:0] MLT_MINUS = 2'h3;

   localparam int EV_INVALID = 0;
   localparam int EV_HALT    = 1;
   localparam int EV_EARLY   = 2;

   typedef enum logic [2:0] {
      SYM_DATA, SYM_IDLE, SYM_J, SYM_K, SYM_T, SYM_R, SYM_HALT, SYM_BAD
   } fpc_sym_t;

   function automatic logic [4:0] fpc_encode(input logic [3:0] nib);
      logic [4:0] c;
      case (nib)
         4'h0:    c = 5'h1e;
         4'h1:    c = 5'h09;
         4'h2:    c = 5'h14;
         4'h3:    c = 5'h15;
         4'h4:    c = 5'h0a;
         4'h5:    c = 5'h0b;
         4'h6:    c = 5'h0e;
         4'h7:    c = 5'h0f;
         4'h8:    c = 5'h12;
         4'h9:    c = 5'h13;
         4'ha:    c = 5'h16;
         4'hb:    c = 5'h17;
         4'hc:    c = 5'h1a;
         4'hd:    c = 5'h1b;
         4'he:    c = 5'h1c;
         default: c = 5'h1d;
      endcase
      return c;
   endfunction

   // Picks one of the ten undefined groups from the data nibble.
   function automatic logic [4:0] fpc_invalid(input logic [3:0] nib);
      logic [4:0] c;
      case (nib)
         4'h0:    c = 5'h00;
         4'h1:    c = 5'h01;
         4'h2:    c = 5'h02;
         4'h3:    c = 5'h03;
         4'h4:    c = 5'h05;
         4'h5:    c = 5'h06;
         4'h6:    c = 5'h08;
         4'h7:    c = 5'h0c;
         4'h8:    c = 5'h10;
         default: c = 5'h19;
      endcase
      return c;
   endfunction

   function automatic fpc_sym_t fpc_classify(input logic [4:0] code);
      fpc_sym_t k;
      k = SYM_BAD;
      for (int n = 0; n < 16; n++) begin
         if (fpc_encode(n[3:0]) == code) begin
            k = SYM_DATA;
         end
      end
      case (code)
         CODE_IDLE: k = SYM_IDLE;
         CODE_J:    k = SYM_J;
         CODE_K:    k = SYM_K;
         CODE_T:    k = SYM_T;
         CODE_R:    k = SYM_R;
         CODE_HALT: k = SYM_HALT;
         default:   k = k;
      endcase
      return k;
   endfunction

   function automatic logic [3:0] fpc_decode(input logic [4:0] code);
      logic [3:0] d;
      d = 4'h0;
      for (int n = 0; n < 16; n++) begin
         if (fpc_encode(n[3:0]) == code) begin
            d = n[3:0];
         end
      end
      return d;
   endfunction

endpackage

// ### fpc_line_pmd.sv
`timescale 1ns/1ps

module fpc_line_pmd
   import fpc_pkg::*;
(
   input  wire logic              clk_line,
   input  wire logic              rst_n,
   input  wire logic              speed_100,
   input  wire logic              bypass,
   input  wire logic              seed_load,
   input  wire logic [LFSR_W-1:0] seed,
   input  wire logic              tx_bit,
   input  wire logic              ten_level,
   output logic                   line_out_positive,
   output logic                   line_out_negative,
   input  wire logic              line_in_positive,
   input  wire logic              line_in_negative,
   output logic                   rx_bit,
   output logic                   rx_locked
);

   logic [LFSR_W-1:0] tx_lfsr;
   logic              tx_key;
   logic              scr_bit;
   logic              tx_nrzi;
   logic [1:0]        tx_phase;
   logic [1:0]        next_phase;

   assign tx_key     = tx_lfsr[TAP_HI] ^ tx_lfsr[TAP_LO];
   assign scr_bit    = bypass ? tx_bit : (tx_bit ^ tx_key);
   // NRZI step then three-level step on every NRZI one.
   assign next_phase = (tx_nrzi ^ scr_bit) ? tx_phase + 2'h1 : tx_phase;

   always_ff @(posedge clk_line or negedge rst_n) begin
      if (!rst_n) begin
         tx_lfsr <= '0;
      end else if (seed_load) begin
         tx_lfsr <= seed;
      end else begin
         tx_lfsr <= {tx_lfsr[LFSR_W-2:0], tx_key};
      end
   end

   always_ff @(posedge clk_line or negedge rst_n) begin
      if (!rst_n) begin
         tx_nrzi           <= 1'b0;
         tx_phase          <= 2'h0;
         line_out_positive <= 1'b0;
         line_out_negative <= 1'b0;
      end else begin
         tx_nrzi  <= tx_nrzi ^ scr_bit;
         tx_phase <= next_phase;
         if (speed_100) begin
            line_out_positive <= (next_phase == MLT_PLUS);
            line_out_negative <= (next_phase == MLT_MINUS);
         end else begin
            line_out_positive <= ten_level;
            line_out_negative <= ~ten_level;
         end
      end
   end

   logic [1:0]        pos_sync;
   logic [1:0]        neg_sync;
   logic [1:0]        lvl;
   logic              rx_nrzi;
   logic              rx_nrzi_prev;
   logic              rx_nrz;
   logic [LFSR_W-1:0] rx_lfsr;
   logic              rx_key;
   logic [3:0]        lock_cnt;

   always_ff @(posedge clk_line or negedge rst_n) begin
      if (!rst_n) begin
         pos_sync <= 2'h0;
         neg_sync <= 2'h0;
      end else begin
         pos_sync <= {pos_sync[0], line_in_positive};
         neg_sync <= {neg_sync[0], line_in_negative};
      end
   end

   // A change of line level is an NRZI one; NRZI is then undone.
   assign rx_nrzi = ({pos_sync[1], neg_sync[1]} != lvl);
   assign rx_nrz  = rx_nrzi ^ rx_nrzi_prev;
   assign rx_key  = rx_lfsr[TAP_HI] ^ rx_lfsr[TAP_LO];

   always_ff @(posedge clk_line or negedge rst_n) begin
      if (!rst_n) begin
         lvl          <= 2'h0;
         rx_nrzi_prev <= 1'b0;
         rx_lfsr      <= '0;
         lock_cnt     <= 4'h0;
         rx_locked    <= 1'b0;
         rx_bit       <= 1'b1;
      end else begin
         lvl          <= {pos_sync[1], neg_sync[1]};
         rx_nrzi_prev <= rx_nrzi;
         if (bypass) begin
            rx_locked <= 1'b1;
            rx_bit    <= rx_nrz;
         end else if (!rx_locked) begin
            // Idle carries all ones, so the key bit is the inverted line bit.
            // Lock only after a run of correct key predictions, so bits from
            // before the far scrambler was seeded cannot train a wrong state.
            rx_lfsr  <= {rx_lfsr[LFSR_W-2:0], ~rx_nrz};
            if (rx_key == ~rx_nrz) begin
               lock_cnt <= lock_cnt + 4'h1;
            end else begin
               lock_cnt <= 4'h0;
            end
            rx_locked <= (lock_cnt == LOCK_BITS) && (rx_key == ~rx_nrz);
            rx_bit   <= 1'b1;
         end else begin
            rx_lfsr <= {rx_lfsr[LFSR_W-2:0], rx_key};
            rx_bit  <= rx_nrz ^ rx_key;
         end
      end
   end

endmodule // fpc_line_pmd

// ### fpc_pcs_top.sv
`timescale 1ns/1ps

module fpc_pcs_top
   import fpc_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             force_invalid,
   input  wire logic             symbol_mode,
   input  wire logic             speed_100,
   input  wire logic             full_duplex,
   input  wire logic [4:0]       phy_addr,
   input  wire logic             status_clear,
   output logic                  invalid_code_seen,
   output logic                  halt_seen,
   output logic                  early_end_seen,
   input  wire logic             clk_line,
   output logic                  tx_nibble_take,
   input  wire logic             tx_en,
   input  wire logic [NIB_W-1:0] txd,
   input  wire logic             tx_er,
   input  wire logic             ten_level,
   output logic                  rx_nibble_valid,
   output logic [NIB_W-1:0]      rxd,
   output logic                  rx_dv,
   output logic                  rx_er,
   output logic                  crs,
   output logic                  col,
   output logic                  line_out_positive,
   output logic                  line_out_negative,
   input  wire logic             line_in_positive,
   input  wire logic             line_in_negative
);

   // Configuration from the system side, resynchronised onto the link clock.
   // The address is static while the link runs, so per-bit sync is enough.
   logic [1:0] finv_s;
   logic [1:0] sym_s;
   logic [1:0] spd_s;
   logic [1:0] fd_s;
   logic [4:0] addr_s1;
   logic [4:0] addr_s2;
   logic [1:0] seed_wait;
   logic       seed_load;

   always_ff @(posedge clk_line or negedge rst_n) begin
      if (!rst_n) begin
         finv_s  <= 2'h0;
         sym_s   <= 2'h0;
         spd_s   <= 2'h0;
         fd_s    <= 2'h0;
         addr_s1 <= 5'h00;
         addr_s2 <= 5'h00;
      end else begin
         finv_s  <= {finv_s[0], force_invalid};
         sym_s   <= {sym_s[0], symbol_mode};
         spd_s   <= {spd_s[0], speed_100};
         fd_s    <= {fd_s[0], full_duplex};
         addr_s1 <= phy_addr;
         addr_s2 <= addr_s1;
      end
   end

   // Seed is loaded once the address has passed both synchroniser stages.
   always_ff @(posedge clk_line or negedge rst_n) begin
      if (!rst_n) begin
         seed_wait <= 2'h0;
         seed_load <= 1'b0;
      end else begin
         seed_wait <= {seed_wait[0], 1'b1};
         seed_load <= (seed_wait == 2'h1) && !sym_s[1];
      end
   end

   // Transmit coder.
   typedef enum logic [1:0] {TX_IDLE, TX_SEND_K, TX_DATA, TX_SEND_R} fpc_tx_t;

   fpc_tx_t    tx_state;
   fpc_tx_t    next_tx_state;
   logic [2:0] tx_cnt;
   logic [4:0] tx_sym;
   logic [4:0] next_code;

   assign tx_nibble_take = (tx_cnt == SYM_LAST);

   always_comb begin
      next_tx_state = tx_state;
      next_code     = CODE_IDLE;
      case (tx_state)
         TX_IDLE: begin
            if (tx_en) begin
               next_code     = CODE_J;
               next_tx_state = TX_SEND_K;
            end
         end
         TX_SEND_K: begin
            next_code     = CODE_K;
            next_tx_state = TX_DATA;
         end
         TX_DATA: begin
            if (!tx_en) begin
               next_code     = CODE_T;
               next_tx_state = TX_SEND_R;
            end else if (tx_er) begin
               next_code = finv_s[1] ? fpc_invalid(txd) : CODE_HALT;
            end else begin
               next_code = fpc_encode(txd);
            end
         end
         TX_SEND_R: begin
            next_code     = CODE_R;
            next_tx_state = TX_IDLE;
         end
         default: begin
            next_tx_state = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_line or negedge rst_n) begin
      if (!rst_n) begin
         tx_state <= TX_IDLE;
         tx_cnt   <= 3'h0;
         tx_sym   <= CODE_IDLE;
      end else if (tx_cnt == SYM_LAST) begin
         tx_state <= next_tx_state;
         tx_cnt   <= 3'h0;
         tx_sym   <= next_code;
      end else begin
         tx_cnt <= tx_cnt + 3'h1;
         tx_sym <= {tx_sym[3:0], 1'b1};
      end
   end

   logic rx_bit;
   logic rx_locked;

   fpc_line_pmd u_pmd (
      .clk_line          (clk_line),
      .rst_n             (rst_n),
      .speed_100         (spd_s[1]),
      .bypass            (sym_s[1]),
      .seed_load         (seed_load),
      .seed              ({SEED_UPPER, addr_s2}),
      .tx_bit            (tx_sym[4]),
      .ten_level         (ten_level),
      .line_out_positive (line_out_positive),
      .line_out_negative (line_out_negative),
      .line_in_positive  (line_in_positive),
      .line_in_negative  (line_in_negative),
      .rx_bit            (rx_bit),
      .rx_locked         (rx_locked)
   );

   // Receive decoder.
   typedef enum logic [1:0] {RX_IDLE, RX_CONFIRM, RX_DATA} fpc_rx_t;

   fpc_rx_t          rx_state;
   logic [WIN_W-1:0] rsr;
   logic [WIN_W-1:0] next_rsr;
   logic [2:0]       rx_cnt;
   logic             armed;
   logic             t_seen;
   logic             pre2;
   logic [EV_N-1:0]  ev_tgl;
   fpc_sym_t         sym;

   assign next_rsr = {rsr[WIN_W-2:0], rx_bit};
   assign sym      = fpc_classify(next_rsr[4:0]);
   assign crs      = (rx_state != RX_IDLE);
   assign col      = (tx_state != TX_IDLE) && crs && !fd_s[1];

   always_ff @(posedge clk_line or negedge rst_n) begin
      if (!rst_n) begin
         rx_state        <= RX_IDLE;
         rsr             <= WIN_ONES;
         rx_cnt          <= 3'h0;
         armed           <= 1'b0;
         t_seen          <= 1'b0;
         pre2            <= 1'b0;
         ev_tgl          <= '0;
         rx_nibble_valid <= 1'b0;
         rxd             <= 4'h0;
         rx_dv           <= 1'b0;
         rx_er           <= 1'b0;
      end else begin
         rsr             <= next_rsr;
         rx_nibble_valid <= 1'b0;
         rx_er           <= 1'b0;
         rx_cnt          <= rx_cnt + 3'h1;
         pre2            <= 1'b0;
         if (pre2) begin
            rx_nibble_valid <= 1'b1;
            rxd             <= PREAMBLE_NIBBLE;
         end
         case (rx_state)
            RX_IDLE: begin
               rx_dv <= 1'b0;
               if (rx_locked && !rx_bit) begin
                  if (armed && rsr[0]) begin
                     rx_state <= RX_CONFIRM;
                     rx_cnt   <= 3'h0;
                     armed    <= 1'b0;
                  end else begin
                     armed <= 1'b1;
                  end
               end else if (next_rsr == WIN_ONES) begin
                  armed <= 1'b0;
               end
            end
            RX_CONFIRM: begin
               if (rx_cnt == CONFIRM_LAST) begin
                  if (next_rsr == {CODE_J, CODE_K}) begin
                     rx_state        <= RX_DATA;
                     rx_cnt          <= 3'h0;
                     t_seen          <= 1'b0;
                     rx_dv           <= 1'b1;
                     rx_nibble_valid <= 1'b1;
                     rxd             <= PREAMBLE_NIBBLE;
                     pre2            <= 1'b1;
                  end else begin
                     rx_state        <= RX_IDLE;
                     rx_er           <= 1'b1;
                     rx_nibble_valid <= 1'b1;
                  end
               end
            end
            RX_DATA: begin
               if (rx_cnt == SYM_LAST) begin
                  rx_cnt <= 3'h0;
                  t_seen <= 1'b0;
                  if (t_seen) begin
                     rx_state <= RX_IDLE;
                     rx_dv    <= 1'b0;
                     if (sym != SYM_R) begin
                        rx_er           <= 1'b1;
                        rx_nibble_valid <= 1'b1;
                     end
                  end else begin
                     case (sym)
                        SYM_DATA: begin
                           rx_nibble_valid <= 1'b1;
                           rxd             <= fpc_decode(next_rsr[4:0]);
                        end
                        SYM_T: begin
                           t_seen <= 1'b1;
                        end
                        SYM_IDLE: begin
                           rx_state           <= RX_IDLE;
                           rx_dv              <= 1'b0;
                           rx_er              <= 1'b1;
                           rx_nibble_valid    <= 1'b1;
                           ev_tgl[EV_EARLY]   <= ~ev_tgl[EV_EARLY];
                        end
                        SYM_HALT: begin
                           rx_er              <= 1'b1;
                           rx_nibble_valid    <= 1'b1;
                           ev_tgl[EV_HALT]    <= ~ev_tgl[EV_HALT];
                        end
                        SYM_BAD: begin
                           rx_er              <= 1'b1;
                           rx_nibble_valid    <= 1'b1;
                           ev_tgl[EV_INVALID] <= ~ev_tgl[EV_INVALID];
                        end
                        default: begin
                           rx_er           <= 1'b1;
                           rx_nibble_valid <= 1'b1;
                        end
                     endcase
                  end
               end
            end
            default: begin
               rx_state <= RX_IDLE;
            end
         endcase
      end
   end

   // Event toggles cross into the system clock; flags are sticky until
   // cleared, and a new event in the clearing cycle wins over the clear.
   logic [EV_N-1:0] ev_s1;
   logic [EV_N-1:0] ev_s2;
   logic [EV_N-1:0] ev_s3;
   logic [EV_N-1:0] flags;

   genvar gi;
   generate
      for (gi = 0; gi < EV_N; gi++) begin : g_ev
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               ev_s1[gi] <= 1'b0;
               ev_s2[gi] <= 1'b0;
               ev_s3[gi] <= 1'b0;
               flags[gi] <= 1'b0;
            end else begin
               ev_s1[gi] <= ev_tgl[gi];
               ev_s2[gi] <= ev_s1[gi];
               ev_s3[gi] <= ev_s2[gi];
               flags[gi] <= (ev_s2[gi] ^ ev_s3[gi]) | (flags[gi] & ~status_clear);
            end
         end
      end
   endgenerate

   assign invalid_code_seen = flags[EV_INVALID];
   assign halt_seen         = flags[EV_HALT];
   assign early_end_seen    = flags[EV_EARLY];

endmodule // fpc_pcs_top

// ### fpc_pcs_properties.sv
`timescale 1ns/1ps

module fpc_pcs_properties
   import fpc_pkg::*;
(
   input wire logic             clk_sys,
   input wire logic             clk_line,
   input wire logic             rst_n,
   input wire logic             full_duplex,
   input wire logic             speed_100,
   input wire logic             status_clear,
   input wire logic             invalid_code_seen,
   input wire logic             halt_seen,
   input wire logic             early_end_seen,
   input wire logic             tx_nibble_take,
   input wire logic             rx_nibble_valid,
   input wire logic [NIB_W-1:0] rxd,
   input wire logic             rx_dv,
   input wire logic             rx_er,
   input wire logic             crs,
   input wire logic             col,
   input wire logic             line_out_positive,
   input wire logic             line_out_negative
);
   fdx_col_low_a: assert property (@(posedge clk_line) disable iff (!rst_n)
      full_duplex && $past(full_duplex, 3) |-> !col) else $error("collision in full duplex");
   level_excl_a: assert property (@(posedge clk_line) disable iff (!rst_n)
      !(line_out_positive && line_out_negative)) else $error("both line levels high");
   plus_step_a: assert property (@(posedge clk_line) disable iff (!rst_n)
      speed_100 && line_out_positive |=> !line_out_negative) else $error("plus to minus jump");
   minus_step_a: assert property (@(posedge clk_line) disable iff (!rst_n)
      speed_100 && line_out_negative |=> !line_out_positive) else $error("minus to plus jump");
   take_period_a: assert property (@(posedge clk_line) disable iff (!rst_n)
      tx_nibble_take |=> !tx_nibble_take [*4] ##1 tx_nibble_take) else $error("take spacing");
   err_valid_a: assert property (@(posedge clk_line) disable iff (!rst_n)
      rx_er |-> rx_nibble_valid) else $error("receive error without nibble");
   start_pair_a: assert property (@(posedge clk_line) disable iff (!rst_n)
      $rose(rx_dv) |-> (rx_nibble_valid && rxd == PREAMBLE_NIBBLE) ##1
      (rx_nibble_valid && rxd == PREAMBLE_NIBBLE)) else $error("frame start nibbles");
   carrier_on_a: assert property (@(posedge clk_line) disable iff (!rst_n)
      $rose(rx_dv) |-> crs) else $error("data valid without carrier");
   invalid_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      invalid_code_seen && !status_clear |=> invalid_code_seen) else $error("invalid flag lost");
   halt_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      halt_seen && !status_clear |=> halt_seen) else $error("halt flag lost");
   early_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      early_end_seen && !status_clear |=> early_end_seen) else $error("early end flag lost");
endmodule // fpc_pcs_properties

bind fpc_pcs_top fpc_pcs_properties u_props (
   .clk_sys(clk_sys), .clk_line(clk_line), .rst_n(rst_n), .full_duplex(full_duplex),
   .speed_100(speed_100), .status_clear(status_clear), .invalid_code_seen(invalid_code_seen),
   .halt_seen(halt_seen), .early_end_seen(early_end_seen), .tx_nibble_take(tx_nibble_take),
   .rx_nibble_valid(rx_nibble_valid), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs),
   .col(col), .line_out_positive(line_out_positive), .line_out_negative(line_out_negative)
);

// ### fpc_link_partner.sv
`timescale 1ns/1ps

module fpc_link_partner (
   input  wire logic clk_line,
   input  wire logic rst_n,
   input  wire logic cut,
   input  wire logic tx_pos,
   input  wire logic tx_neg,
   output logic      rx_pos,
   output logic      rx_neg
);
   logic [2:0] phase;

   // Echoes the line back; when cut it sends its own idle stream of ones.
   always_ff @(posedge clk_line or negedge rst_n) begin
      if (!rst_n) begin
         phase  <= 3'h0;
         rx_pos <= 1'b0;
         rx_neg <= 1'b0;
      end else if (cut) begin
         // One level step every second bit is an unscrambled stream of ones.
         phase  <= phase + 3'h1;
         rx_pos <= (phase[2:1] == 2'h1);
         rx_neg <= (phase[2:1] == 2'h3);
      end else begin
         rx_pos <= tx_pos;
         rx_neg <= tx_neg;
      end
   end
endmodule // fpc_link_partner

// ### fast_ethernet_pcs_coding_tb_top.sv
`timescale 1ns/1ps

module fast_ethernet_pcs_coding_tb_top
   import fpc_pkg::*;
;
   logic       clk_sys, clk_line, rst_n, force_invalid, symbol_mode, full_duplex;
   logic       status_clear, tx_en, tx_er, cut, col_seen, take, inv, hlt, early;
   logic       rxv, rx_dv, rx_er, crs, col, lop, lon, lip, lin;
   logic [3:0] txd, rxd;
   logic [1:0] prev;
   logic [3:0] rxq[$];
   int         er_cnt, holds, fail_count, total_checks;

   fpc_pcs_top uut (
      .clk_sys(clk_sys), .rst_n(rst_n), .force_invalid(force_invalid),
      .symbol_mode(symbol_mode), .speed_100(1'b1), .full_duplex(full_duplex),
      .phy_addr(5'h0_0005), .status_clear(status_clear), .invalid_code_seen(inv),
      .halt_seen(hlt), .early_end_seen(early), .clk_line(clk_line), .tx_nibble_take(take),
      .tx_en(tx_en), .txd(txd), .tx_er(tx_er), .ten_level(1'b0), .rx_nibble_valid(rxv),
      .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .col(col),
      .line_out_positive(lop), .line_out_negative(lon),
      .line_in_positive(lip), .line_in_negative(lin)
   );

   fpc_link_partner u_partner (
      .clk_line(clk_line), .rst_n(rst_n), .cut(cut), .tx_pos(lop), .tx_neg(lon),
      .rx_pos(lip), .rx_neg(lin)
   );

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial begin
      clk_line = 1'b0;
      #7;
      forever #80 clk_line = ~clk_line;
   end

   // Collects delivered nibbles and watches the wire between clock edges.
   always @(negedge clk_line) begin
      if (rxv === 1'b1) begin
         rxq.push_back(rxd);
         if (rx_er === 1'b1) er_cnt++;
      end
      if (col === 1'b1) col_seen = 1'b1;
      if ({lop, lon} === prev) holds++;
      prev = {lop, lon};
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic wait_take;
      int n;
      @(negedge clk_line);
      for (n = 0; n < 12 && take !== 1'b1; n++) @(negedge clk_line);
      if (n == 12) begin
         fail_count++;
         test_done();
      end
      @(posedge clk_line);
   endtask

   task automatic reset_dut(input logic sym);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      symbol_mode <= sym;
      repeat (6) @(posedge clk_sys);
      repeat (2) @(posedge clk_line);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (40) @(posedge clk_line);
   endtask

   // Sends two start nibbles then nd data nibbles, tx_er on data index er_at.
   task automatic frame(input int nd, input int er_at);
      int n;
      rxq.delete();
      er_cnt = 0;
      col_seen = 1'b0;
      for (int k = 0; k < nd + 2; k++) begin
         wait_take();
         tx_en <= 1'b1;
         txd <= (k < 2) ? PREAMBLE_NIBBLE : 4'(k - 2);
         tx_er <= (k - 2 == er_at);
      end
      wait_take();
      tx_en <= 1'b0;
      tx_er <= 1'b0;
      for (n = 0; n < 100 && crs !== 1'b0; n++) @(posedge clk_line);
      if (n == 100) chk("carrier_drop", 8'(crs), 8'h00);
      repeat (4) @(posedge clk_line);
   endtask

   task automatic chk_rx(input int nd);
      chk("nibble_count", 8'(rxq.size()), 8'(nd + 2));
      for (int i = 0; i < nd + 2; i++)
         chk("nibble", 8'(rxq[i]), 8'((i < 2) ? PREAMBLE_NIBBLE : 4'(i - 2)));
   endtask

   // Unscrambled idle steps the line every second bit: exactly half are holds.
   task automatic idle_holds(input logic sym, input logic [7:0] exp);
      holds = 0;
      repeat (40) @(posedge clk_line);
      chk("idle_holds", sym ? 8'(holds) : 8'(holds != 0), exp);
   endtask

   initial begin
      {rst_n, force_invalid, symbol_mode, full_duplex, status_clear} = 5'h0_0;
      {tx_en, tx_er, cut, col_seen} = 4'h0;
      txd = 4'h0;
      prev = 2'h0;
      er_cnt = 0;
      holds = 0;
      fail_count = 0;
      total_checks = 0;
      reset_dut(1'b0);
      idle_holds(1'b0, 8'h01);
      frame(16, 99);
      chk_rx(16);
      chk("col_half", 8'(col_seen), 8'h01);
      chk("clean_er", 8'(er_cnt), 8'h00);
      frame(4, 1);
      @(negedge clk_sys);
      chk("halt_er", 8'(er_cnt), 8'h01);
      chk("halt_flag", 8'(hlt), 8'h01);
      chk("no_invalid", 8'(inv), 8'h00);
      @(posedge clk_sys);
      force_invalid <= 1'b1;
      frame(4, 1);
      @(negedge clk_sys);
      chk("invalid_flag", 8'(inv), 8'h01);
      @(posedge clk_sys);
      force_invalid <= 1'b0;
      full_duplex <= 1'b1;
      frame(2, 99);
      chk("col_full", 8'(col_seen), 8'h00);
      chk("no_early", 8'(early), 8'h00);
      @(posedge clk_sys);
      status_clear <= 1'b1;
      repeat (2) @(posedge clk_sys);
      status_clear <= 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("clear_flags", 8'({inv, hlt}), 8'h00);
      reset_dut(1'b1);
      idle_holds(1'b1, 8'h14);
      frame(3, 99);
      chk_rx(3);
      fork
         frame(8, 99);
         begin
            repeat (40) @(posedge clk_line);
            cut <= 1'b1;
         end
      join
      repeat (8) @(negedge clk_sys);
      chk("early_flag", 8'(early), 8'h01);
      chk("early_er", 8'(er_cnt != 0), 8'h01);
      test_done();
   end
endmodule // fast_ethernet_pcs_coding_tb_top
